// ===== hw/flash_protect_consts.vh
// Constants for the flash program-protection block.
// Included by the protection logic and its early-boot timer.
`ifndef FLASH_PROTECT_CONSTS_VH
`define FLASH_PROTECT_CONSTS_VH
`define FPC_SFR_ADDR 8'hB2
`define FPC_EARLY_BOOT_BIT 7
`define FPC_CODE_LOCK_BIT 6
`define FPC_MEM_EN_BIT 1
`define FPC_PROG_WE_BIT 0
`define FPC_RESET 8'h00
`define ACC_ADDR 16'h2005
`define ACC_EMU_CLK_OFF_BIT 5
`define ACC_RESET 8'h00
`define EARLY_BOOT_CYCLES 6'd32
`define PAGE_ZERO 7'h00
`endif

// ===== hw/early_boot_timer.v
// Counts the early-boot cycles after reset release.
// Assumes one cycle per processor instruction on clk_sys.
`timescale 1ns/1ps
`include "flash_protect_consts.vh"
module early_boot_timer (
    input wire clk_sys,
    input wire rstn,
    output reg early_boot_q
);
    reg [5:0] count_q;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_q <= 6'h00;
            early_boot_q <= 1'b1;
        end else if (early_boot_q) begin
            count_q <= count_q + 6'h01;
            if (count_q == `EARLY_BOOT_CYCLES - 6'h01) begin
                early_boot_q <= 1'b0;
            end
        end
    end
endmodule

// ===== hw/flash_code_protection.v
// Program-security logic: early-boot window, sticky code lock, gating of
// emulator, flash page-zero and external-read requests.
// Assumes the processor SFR and config-RAM write/read strobes are synchronous
// to clk_sys, and flash/emulator requests are one-cycle pulses.
// Summary of operation
// - While locked, every emulator operation except global erase is refused.
// - The lock can only be set by processor code during the 32-cycle early boot.
// - Once set, the lock is released only by chip reset; a global erase leaves it set.
// - A global erase also clears the engine program RAM regardless of the lock.
// - During the first 32 cycles after reset the emulator is held off entirely.
// - Bit 7 of register 0xB2 is a read-only flag that is high during early boot.
// - After early boot the emulator may be enabled and take control, subject to lock.
// - The lock bit at 0xB2 bit 6 is cleared on every processor reset.
// - The lock bit accepts only writes of one; writing zero leaves it unchanged.
// - While locked, all external reads of program code are blocked.
// - While locked, page-zero erase is refused from both sources, but a processor erase lands on page zero if a live emulator request names page zero.
// - While locked, page-zero writes are suppressed from both sources, but a processor write lands on page zero if a live emulator request names page zero.
// - Writing one to the emulator clock disable bit stops the emulator clock.
`timescale 1ns/1ps
`include "flash_protect_consts.vh"
module flash_code_protection (
    input wire clk_sys,
    input wire rstn,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_q,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [15:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    output reg [7:0] cfg_rdata_q,
    input wire emu_enable,
    input wire emu_req,
    input wire emu_global_erase,
    input wire emu_page_erase,
    input wire emu_write,
    input wire emu_read,
    input wire [6:0] emu_page,
    input wire cpu_page_erase,
    input wire cpu_write,
    input wire [6:0] cpu_page,
    input wire ext_code_read,
    input wire [7:0] flash_rdata,
    output reg emu_grant_q,
    output reg emu_clk_en_q,
    output reg emu_refused_q,
    output reg [7:0] emu_rdata_q,
    output reg ext_read_grant_q,
    output reg flash_global_erase_q,
    output reg engine_ram_clear_q,
    output reg flash_page_erase_q,
    output reg flash_write_q,
    output reg [6:0] flash_page_q,
    output reg code_lock_q,
    output reg early_boot_out_q
);

    wire early_boot;
    reg code_lock_bit_q;
    reg code_lock_bit_d;
    reg mem_en_q;
    reg mem_en_d;
    reg prog_we_q;
    reg prog_we_d;
    reg [7:0] acc_q;
    reg [7:0] acc_d;
    reg [7:0] sfr_rdata_d;
    reg [7:0] cfg_rdata_d;
    reg emu_grant_d;
    reg emu_clk_en_d;
    reg emu_refused_d;
    reg [7:0] emu_rdata_d;
    reg ext_read_grant_d;
    reg flash_global_erase_d;
    reg engine_ram_clear_d;
    reg flash_page_erase_d;
    reg flash_write_d;
    reg [6:0] flash_page_d;
    reg code_lock_d;
    reg early_boot_out_d;

    wire emulator_clock_off = acc_q[`ACC_EMU_CLK_OFF_BIT];
    wire sfr_hit = sfr_addr == `FPC_SFR_ADDR;
    wire cfg_hit = cfg_addr == `ACC_ADDR;
    // A lock write outside early boot is dropped, so late firmware cannot arm it
    wire lock_write = sfr_wr && sfr_hit && sfr_wdata[`FPC_CODE_LOCK_BIT];
    wire emu_live = !early_boot && emu_enable && !emulator_clock_off;
    wire emu_other = emu_page_erase || emu_write || emu_read;
    wire emu_ok_other = emu_live && !code_lock_bit_q;
    // Global erase stays open under lock, so a locked part can always be recovered
    wire emu_ok_erase = emu_live && emu_global_erase;
    wire emu_accept = emu_req && (emu_ok_erase || (emu_ok_other && emu_other));

    early_boot_timer u_timer (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .early_boot_q(early_boot)
    );

    // Requester 0 is the processor, requester 1 the emulator
    wire [1:0] req_erase;
    wire [1:0] req_write;
    wire [13:0] req_page;
    wire [1:0] erase_ok;
    wire [1:0] write_ok;
    assign req_erase = {emu_req && emu_ok_other && emu_page_erase, cpu_page_erase};
    assign req_write = {emu_req && emu_ok_other && emu_write, cpu_write};
    assign req_page = {emu_page, cpu_page};
    genvar src;
    generate
        for (src = 0; src < 2; src = src + 1) begin : page_guard
            wire page_zero = req_page[src * 7 +: 7] == `PAGE_ZERO;
            // Page zero holds the boot code; while locked erase and write requests that name page zero are blocked here
            wire shielded = code_lock_bit_q && page_zero;
            assign erase_ok[src] = req_erase[src] && !shielded;
            assign write_ok[src] = req_write[src] && !shielded;
        end
    endgenerate

    always @* begin
        code_lock_bit_d = code_lock_bit_q;
        mem_en_d = mem_en_q;
        prog_we_d = prog_we_q;
        acc_d = acc_q;
        if (sfr_wr && sfr_hit) begin
            mem_en_d = sfr_wdata[`FPC_MEM_EN_BIT];
            prog_we_d = sfr_wdata[`FPC_PROG_WE_BIT];
        end
        // Set-only: a zero write or a global erase leaves it, only reset clears it
        if (lock_write && early_boot) begin
            code_lock_bit_d = 1'b1;
        end
        if (cfg_wr && cfg_hit) begin
            acc_d = cfg_wdata;
        end
    end

    always @* begin
        sfr_rdata_d = 8'h00;
        if (sfr_rd && sfr_hit) begin
            // Bits 5 to 2 are not implemented and read as zero
            sfr_rdata_d[`FPC_EARLY_BOOT_BIT] = early_boot;
            sfr_rdata_d[`FPC_CODE_LOCK_BIT] = code_lock_bit_q;
            sfr_rdata_d[`FPC_MEM_EN_BIT] = mem_en_q;
            sfr_rdata_d[`FPC_PROG_WE_BIT] = prog_we_q;
        end
        cfg_rdata_d = 8'h00;
        if (cfg_rd && cfg_hit) begin
            cfg_rdata_d = acc_q;
        end
    end

    // Answers are decided here and registered below: one cycle after the request
    always @* begin
        emu_clk_en_d = !emulator_clock_off && !early_boot;
        emu_grant_d = emu_accept;
        emu_refused_d = emu_req && !emu_accept;
        emu_rdata_d = 8'h00;
        // No data is presented for refused reads
        if (emu_req && emu_read && emu_ok_other) begin
            emu_rdata_d = flash_rdata;
        end
        ext_read_grant_d = ext_code_read && !code_lock_bit_q;
        flash_global_erase_d = emu_req && emu_ok_erase;
        engine_ram_clear_d = emu_req && emu_ok_erase;
        flash_page_erase_d = |erase_ok;
        flash_write_d = |write_ok;
        flash_page_d = cpu_page;
        // The emulator wins the page address when both are active
        if (emu_req && emu_live) begin
            flash_page_d = emu_page;
        end
        code_lock_d = code_lock_bit_q;
        early_boot_out_d = early_boot;
    end

    // The lock must never outlive a reset, hence the asynchronous clear
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            code_lock_bit_q <= 1'b0;
            mem_en_q <= 1'b0;
            prog_we_q <= 1'b0;
            acc_q <= `ACC_RESET;
            sfr_rdata_q <= 8'h00;
            cfg_rdata_q <= 8'h00;
            emu_grant_q <= 1'b0;
            emu_clk_en_q <= 1'b0;
            emu_refused_q <= 1'b0;
            emu_rdata_q <= 8'h00;
            ext_read_grant_q <= 1'b0;
            flash_global_erase_q <= 1'b0;
            engine_ram_clear_q <= 1'b0;
            flash_page_erase_q <= 1'b0;
            flash_write_q <= 1'b0;
            flash_page_q <= 7'h00;
            code_lock_q <= 1'b0;
            // Early boot shows from reset on, so the emulator is held off at once
            early_boot_out_q <= 1'b1;
        end else begin
            code_lock_bit_q <= code_lock_bit_d;
            mem_en_q <= mem_en_d;
            prog_we_q <= prog_we_d;
            acc_q <= acc_d;
            sfr_rdata_q <= sfr_rdata_d;
            cfg_rdata_q <= cfg_rdata_d;
            emu_grant_q <= emu_grant_d;
            emu_clk_en_q <= emu_clk_en_d;
            emu_refused_q <= emu_refused_d;
            emu_rdata_q <= emu_rdata_d;
            ext_read_grant_q <= ext_read_grant_d;
            flash_global_erase_q <= flash_global_erase_d;
            engine_ram_clear_q <= engine_ram_clear_d;
            flash_page_erase_q <= flash_page_erase_d;
            flash_write_q <= flash_write_d;
            flash_page_q <= flash_page_d;
            code_lock_q <= code_lock_d;
            early_boot_out_q <= early_boot_out_d;
        end
    end
endmodule

// ===== bench/fcp_props.sv
// Port checks for the flash protection block.
// Bound by name into every instance of it.
`timescale 1ns/1ps
module fcp_props (input wire clk_sys, rstn, emu_req, emu_global_erase, cpu_write,
    cpu_page_erase, code_lock_q, emu_grant_q, emu_refused_q, early_boot_out_q, flash_write_q,
    flash_page_erase_q, flash_global_erase_q, engine_ram_clear_q, ext_read_grant_q,
    input wire [6:0] cpu_page, input wire [7:0] emu_rdata_q);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire p0 = code_lock_q && cpu_page == 7'h00 && !emu_req;
    chk_lock_refuse: assert property (code_lock_q && emu_req && !emu_global_erase
        |=> emu_refused_q && !emu_grant_q) else $error("locked grant");
    chk_lock_boot: assert property ($rose(code_lock_q) |-> $past(early_boot_out_q))
        else $error("late lock");
    chk_lock_stays: assert property (code_lock_q |=> code_lock_q) else $error("unlock");
    chk_erase_ram: assert property (flash_global_erase_q == engine_ram_clear_q)
        else $error("ram clear");
    chk_boot_hold: assert property (emu_req |=> !(early_boot_out_q && emu_grant_q))
        else $error("boot grant");
    chk_zero_erase: assert property (p0 && cpu_page_erase |=> !flash_page_erase_q)
        else $error("page erase");
    chk_zero_write: assert property (p0 && cpu_write |=> !flash_write_q) else $error("write");
    chk_lock_read: assert property (code_lock_q |=> !ext_read_grant_q)
        else $error("locked read");
    chk_refused_data: assert property (emu_refused_q |-> emu_rdata_q == 8'h00)
        else $error("data leak");
    cover property (flash_global_erase_q);
    cover property (emu_refused_q && code_lock_q);
    cover property ($fell(early_boot_out_q));
endmodule
bind flash_code_protection fcp_props fcp_props_inst (.*);

// ===== bench/emu_model.sv
// Emulator tool model, one request per go call.
// Page lines show the inverse once released.
`timescale 1ns/1ps
module emu_model (input wire clk_sys, output reg emu_req = 0, output reg [3:0] kind = 0,
    output reg [6:0] emu_page = 0);
    task go(input [3:0] k, input [6:0] p);
        @(posedge clk_sys); emu_req <= 1; kind <= k; emu_page <= p;
        @(posedge clk_sys); emu_req <= 0; kind <= 0; emu_page <= ~p;
    endtask
endmodule

// ===== bench/flash_code_protection_test.sv
// Bench for the flash protection block against integer model state.
// Emulator requests go through emu_model.
`timescale 1ns/1ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("unexpected %0t %h %h", $time, a, b); end end
module flash_code_protection_test;
    reg clk_sys = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, cfg_wr = 0, cfg_rd = 0, emu_enable = 0,
        cpu_page_erase = 0, cpu_write = 0, ext_code_read = 0;
    reg [7:0] sfr_addr = 0, sfr_wdata = 0, cfg_wdata = 0, flash_rdata = 0;
    reg [15:0] cfg_addr = 0;
    reg [6:0] cpu_page = 0;
    wire [3:0] kd;
    wire [6:0] emu_page, flash_page_q;
    wire [7:0] sfr_rdata_q, cfg_rdata_q, emu_rdata_q;
    wire emu_req, emu_grant_q, emu_clk_en_q, emu_refused_q, ext_read_grant_q, code_lock_q,
        flash_global_erase_q, engine_ram_clear_q, flash_page_erase_q, flash_write_q, early_boot_out_q;
    wire [3:0] fo = {flash_global_erase_q, engine_ram_clear_q, flash_write_q, flash_page_erase_q};
    integer errors = 0, n_tests = 0, seed = 75150, lk, eb, co, i;
    flash_code_protection flash_code_protection_inst (.*, .emu_global_erase(kd[3]),
        .emu_page_erase(kd[2]), .emu_write(kd[1]), .emu_read(kd[0]));
    emu_model emu_model_inst (.clk_sys, .emu_req, .kind(kd), .emu_page);
    initial forever #50 clk_sys = ~clk_sys;
    initial begin #400000; errors++; conclude; end
    task conclude;
        if (errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task rst; rstn <= 0; repeat (2) @(posedge clk_sys); rstn <= 1; lk = 0; eb = 1; co = 0; endtask
    // Write then read back; c picks config space, else the protect register
    task r(input c, input [15:0] a, input [7:0] d);
        reg [15:0] x;
        @(posedge clk_sys); {cfg_wr, sfr_wr, cfg_addr, sfr_addr} <= {c, !c, a, a[7:0]};
        {cfg_wdata, sfr_wdata} <= {d, d};
        @(posedge clk_sys); {cfg_wr, sfr_wr, cfg_rd, sfr_rd} <= {2'b00, c, !c};
        if (c && a == 16'h2005) co = d[5];
        if (!c && eb && d[6]) lk = 1;
        @(posedge clk_sys); {cfg_rd, sfr_rd} <= 2'b00;
        x = c ? {a == 16'h2005 ? d : 8'h00, 8'h00} : {8'h00, eb[0], lk[0], 4'h0, d[1:0]};
        #1 `CK({cfg_rdata_q, sfr_rdata_q}, x)
        `CK(emu_clk_en_q, !co[0] && !eb[0])
        `CK(code_lock_q, lk[0])
    endtask
    task emu(input [3:0] k);
        reg g;
        @(posedge clk_sys);
        flash_rdata <= 8'($random(seed));
        g = emu_enable && !eb && !co && (!lk || k[3]);
        emu_model_inst.go(k, 7'(k));
        #1 `CK({emu_grant_q, emu_refused_q}, {g, !g})
        `CK(fo, {4{g}} & {k[3], k[3], k[1], k[2]})
        `CK(emu_rdata_q, g & k[0] ? flash_rdata : 8'h00)
    endtask
    task cpu(input e, input [6:0] p);
        reg [2:0] x;
        x = {!e, e, !lk[0]} & {{2{!(lk && p == 0)}}, 1'b1};
        @(posedge clk_sys); {cpu_write, cpu_page_erase, cpu_page, ext_code_read} <= {!e, e, p, 1'b1};
        @(posedge clk_sys); {cpu_write, cpu_page_erase, cpu_page, ext_code_read} <= {2'b00, ~p, 1'b0};
        #1 `CK({fo[1:0], ext_read_grant_q}, x)
        `CK(flash_page_q, p)
    endtask
    initial begin
        rst;
        emu_enable <= 1;
        r(0, 16'h00B2, 8'h02);
        emu(4'h1);
        r(0, 16'h00B2, 8'h41);
        repeat (40) @(posedge clk_sys);
        eb = 0;
        #1 `CK(early_boot_out_q, 1'b0)
        for (i = 0; i < 4; i++) emu(4'h1 << i);
        cpu(0, 7'h00); cpu(1, 7'h00); cpu(0, 7'($random(seed)) | 7'h01);
        r(0, 16'h00B2, 8'h00);
        @(posedge clk_sys);
        rst;
        repeat (40) @(posedge clk_sys);
        eb = 0;
        r(0, 16'h00B2, 8'h40);
        for (i = 0; i < 8; i++) emu(4'h1 << i[1:0]);
        cpu(1, 7'h00);
        r(1, 16'h2004, 8'hFF);
        r(1, 16'h2005, 8'h20);
        emu(4'h1);
        r(1, 16'h2005, 8'h00);
        @(posedge clk_sys) emu_enable <= 0;
        emu(4'h2);
        conclude;
    end
endmodule
